// >>> src/dle_pkg.sv
// Purpose: shared constants and types of the decorated load engine
// Assumes: 32-bit single-layer AHB on both sides, one clock
// Notes: decoration bit positions, address bases, register offsets
package dle_pkg;

	// ========================================================================
	// AHB encodings
	localparam logic [1:0] DLE_HTRANS_IDLE = 2'h0;
	localparam logic [1:0] DLE_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] DLE_SIZE_BYTE = 3'h0;
	localparam logic [2:0] DLE_SIZE_HALF = 3'h1;

	// ========================================================================
	// decorated address fields
	localparam int DLE_TOP_BIT = 31;
	localparam int DLE_SPACE_HI = 30;
	localparam int DLE_SPACE_LO = 29;
	localparam int DLE_OP_HI = 28;
	localparam int DLE_OP_LO = 26;
	localparam int DLE_BIT_HI = 25;
	localparam int DLE_BIT_LO = 21;
	localparam int DLE_EXT_B_HI = 27;
	localparam int DLE_EXT_B_LO = 23;
	localparam int DLE_EXT_W_HI = 22;
	localparam int DLE_EXT_W_LO = 19;
	localparam int DLE_OFF_BIT_HI = 19;
	localparam int DLE_OFF_EXT_HI = 18;
	localparam logic [1:0] DLE_SPACE_SRAM = 2'h1;
	localparam logic [1:0] DLE_SPACE_PERIPH = 2'h2;
	localparam logic [2:0] DLE_OP_CLEAR = 3'h2;
	localparam logic [2:0] DLE_OP_SET = 3'h3;
	localparam logic [31:0] DLE_BASE_SRAM = 32'h2000_0000;
	localparam logic [31:0] DLE_BASE_PERIPH = 32'h4000_0000;

	// ========================================================================
	// register map
	localparam logic [7:0] DLE_REG_CTRL = 8'h00;
	localparam logic [7:0] DLE_REG_STAT = 8'h04;
	localparam logic DLE_CTRL_RESET = 1'h1;
	localparam logic [1:0] DLE_KIND_CLEAR = 2'h1;
	localparam logic [1:0] DLE_KIND_SET = 2'h2;
	localparam logic [1:0] DLE_KIND_EXT = 2'h3;

	typedef enum logic [2:0] {
		DLE_ST_PASS = 3'b000,
		DLE_ST_RMW_RD = 3'b001,
		DLE_ST_RMW_WR = 3'b010,
		DLE_ST_EXT_RD = 3'b011,
		DLE_ST_EXT_RET = 3'b100
	} dle_state_e;

endpackage

// >>> src/dle_field_unit.sv
// Purpose: container alignment, one-hot and field masks of a decorated load
// Assumes: read data lane already chosen by the caller through lane_i
// Notes: purely combinational, the caller registers every result
`timescale 1ns/1ns
module dle_field_unit import dle_pkg::*; (
	input wire logic [31:0] rdata_i,
	input wire logic [2:0] size_i,
	input wire logic [1:0] lane_i,
	input wire logic [4:0] bpos_i,
	input wire logic [3:0] fw_i,
	input wire logic set_i,
	output logic [31:0] mod_o,
	output logic bit_o,
	output logic [31:0] field_o
);
	logic [4:0] sh;
	logic [31:0] cont;
	logic [31:0] cmask;
	logic [4:0] bsel;
	logic [31:0] onehot;
	logic [32:0] wmask;
	logic [31:0] fmask;

	always_comb begin
		sh = {lane_i, 3'b000};
		cont = rdata_i >> sh;
		if (size_i == DLE_SIZE_BYTE) begin
			cmask = 32'h0000_00FF;
			bsel = {2'b00, bpos_i[2:0]};
		end else if (size_i == DLE_SIZE_HALF) begin
			cmask = 32'h0000_FFFF;
			bsel = {1'b0, bpos_i[3:0]};
		end else begin
			cmask = 32'hFFFF_FFFF;
			bsel = bpos_i;
		end
		onehot = 32'h0000_0001 << bsel;
		bit_o = cont[bsel];
		// modified container goes back into its own byte lane
		mod_o = ((set_i ? (cont | onehot) : (cont & ~onehot)) & cmask) << sh;
		// field mask cut at the container top
		wmask = (33'h0_0000_0001 << ({1'b0, fw_i} + 5'h01)) - 33'h0_0000_0001;
		fmask = (wmask[31:0] << bpos_i) & cmask;
		field_o = cont & fmask;
	end
endmodule

// >>> src/dle_wb_regs.sv
// Purpose: Wishbone control and status registers of the decorated load engine
// Assumes: classic single cycle Wishbone, one ack per request
// Notes: unmapped offsets read zero and ignore writes
`timescale 1ns/1ns
module dle_wb_regs import dle_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic done_i,
	input wire logic [1:0] kind_i,
	input wire logic busy_i,
	output logic enable_o
);
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic enable;
		logic [15:0] count;
		logic [1:0] kind;
	} dle_wb_s;

	dle_wb_s q_r;
	dle_wb_s q_nxt;
	logic req;

	always_comb begin
		q_nxt = q_r;
		req = wb_cyc_i && wb_stb_i;
		q_nxt.ack = req && !q_r.ack;
		if (req && !q_r.ack) begin
			if (wb_adr_i == DLE_REG_CTRL) begin
				q_nxt.dat = {31'h0000_0000, q_r.enable};
			end else if (wb_adr_i == DLE_REG_STAT) begin
				q_nxt.dat = {13'h0000, busy_i, q_r.kind, q_r.count};
			end else begin
				q_nxt.dat = 32'h0000_0000;
			end
		end
		// writes land on the edge at which the master sees ack
		if (req && q_r.ack && wb_we_i) begin
			if (wb_adr_i == DLE_REG_CTRL && wb_sel_i[0]) begin
				q_nxt.enable = wb_dat_i[0];
			end
			if (wb_adr_i == DLE_REG_STAT) begin
				q_nxt.count = 16'h0000;
			end
		end
		// a completion in the clearing cycle still counts
		if (done_i) begin
			q_nxt.count = q_nxt.count + 16'h0001;
			q_nxt.kind = kind_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= '{ack: 1'b0, dat: 32'h0000_0000, enable: DLE_CTRL_RESET,
				count: 16'h0000, kind: 2'h0};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign wb_dat_o = q_r.dat;
	assign wb_ack_o = q_r.ack;
	assign enable_o = q_r.enable;
endmodule

// >>> src/dle_engine.sv
// Purpose: decorated load engine between the core AHB master and the memory slaves
// Assumes: AHB single transfers, core and memory on clk_i, synchronous reset
// Notes: undecorated and decorated store traffic passes through unchanged
`timescale 1ns/1ns
module dle_engine import dle_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	// core side
	input wire logic [31:0] s_haddr_i,
	input wire logic [1:0] s_htrans_i,
	input wire logic s_hwrite_i,
	input wire logic [2:0] s_hsize_i,
	input wire logic [3:0] s_hprot_i,
	input wire logic [31:0] s_hwdata_i,
	output logic [31:0] s_hrdata_o,
	output logic s_hready_o,
	output logic s_hresp_o,
	// memory side
	output logic [31:0] m_haddr_o,
	output logic [1:0] m_htrans_o,
	output logic m_hwrite_o,
	output logic [2:0] m_hsize_o,
	output logic [3:0] m_hprot_o,
	output logic [31:0] m_hwdata_o,
	input wire logic [31:0] m_hrdata_i,
	input wire logic m_hready_i,
	input wire logic m_hresp_i,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef struct packed {
		dle_state_e state;
		logic [31:0] addr;
		logic [2:0] size;
		logic [3:0] prot;
		logic [1:0] lane;
		logic set;
		logic [4:0] bpos;
		logic [3:0] fw;
		logic [31:0] data;
		logic [31:0] mod;
	} dle_engine_s;

	dle_engine_s st_r;
	dle_engine_s st_nxt;

	// ========================================================================
	// decode of the core address phase
	logic enable;
	logic [1:0] dec_space;
	logic [2:0] dec_op;
	logic dec_in_space;
	logic dec_ext;
	logic dec_bit;
	logic dec_load;
	logic accept;
	logic [19:0] dec_off;
	logic [31:0] dec_addr;
	logic [1:0] dec_lane;

	always_comb begin
		dec_space = s_haddr_i[DLE_SPACE_HI:DLE_SPACE_LO];
		dec_op = s_haddr_i[DLE_OP_HI:DLE_OP_LO];
		dec_in_space = !s_haddr_i[DLE_TOP_BIT]
			&& (dec_space == DLE_SPACE_SRAM || dec_space == DLE_SPACE_PERIPH);
		dec_ext = dec_op[2];
		dec_bit = (dec_op == DLE_OP_CLEAR) || (dec_op == DLE_OP_SET);
		dec_load = enable && dec_in_space && !s_hwrite_i && (dec_ext || dec_bit)
			&& s_htrans_i[1];
		if (dec_ext) begin
			dec_off = {1'b0, s_haddr_i[DLE_OFF_EXT_HI:0]};
		end else begin
			dec_off = s_haddr_i[DLE_OFF_BIT_HI:0];
		end
		dec_addr = ((dec_space == DLE_SPACE_SRAM) ? DLE_BASE_SRAM : DLE_BASE_PERIPH)
			| {12'h000, dec_off};
		if (s_hsize_i == DLE_SIZE_BYTE) begin
			dec_lane = s_haddr_i[1:0];
		end else if (s_hsize_i == DLE_SIZE_HALF) begin
			dec_lane = {s_haddr_i[1], 1'b0};
		end else begin
			dec_lane = 2'h0;
		end
	end

	// ========================================================================
	// bit and field arithmetic on the memory read data
	logic [31:0] fu_mod;
	logic fu_bit;
	logic [31:0] fu_field;

	dle_field_unit u_field (
		.rdata_i(m_hrdata_i),
		.size_i(st_r.size),
		.lane_i(st_r.lane),
		.bpos_i(st_r.bpos),
		.fw_i(st_r.fw),
		.set_i(st_r.set),
		.mod_o(fu_mod),
		.bit_o(fu_bit),
		.field_o(fu_field)
	);

	// ========================================================================
	// core side answer
	always_comb begin
		s_hrdata_o = m_hrdata_i;
		s_hresp_o = m_hresp_i;
		s_hready_o = m_hready_i;
		case (st_r.state)
			DLE_ST_PASS: begin
				s_hready_o = m_hready_i;
			end
			DLE_ST_RMW_RD, DLE_ST_EXT_RD: begin
				s_hready_o = 1'b0;
				s_hresp_o = 1'b0;
			end
			DLE_ST_RMW_WR: begin
				s_hrdata_o = st_r.data;
				s_hready_o = m_hready_i;
			end
			DLE_ST_EXT_RET: begin
				s_hrdata_o = st_r.data >> st_r.bpos;
				s_hready_o = 1'b1;
				s_hresp_o = 1'b0;
			end
			default: begin
				s_hready_o = m_hready_i;
			end
		endcase
		accept = s_hready_o && s_htrans_i[1];
	end

	// ========================================================================
	// memory side address and write data
	always_comb begin
		m_haddr_o = dec_load ? dec_addr : s_haddr_i;
		m_htrans_o = s_htrans_i;
		m_hwrite_o = s_hwrite_i;
		m_hsize_o = s_hsize_i;
		m_hprot_o = s_hprot_i;
		m_hwdata_o = s_hwdata_i;
		case (st_r.state)
			DLE_ST_RMW_RD: begin
				// core request is held off, only the write may follow the read
				m_haddr_o = st_r.addr;
				m_htrans_o = DLE_HTRANS_NONSEQ;
				m_hwrite_o = 1'b1;
				m_hsize_o = st_r.size;
				m_hprot_o = st_r.prot;
			end
			DLE_ST_EXT_RD: begin
				m_haddr_o = st_r.addr;
				m_htrans_o = DLE_HTRANS_IDLE;
				m_hwrite_o = 1'b0;
				m_hsize_o = st_r.size;
				m_hprot_o = st_r.prot;
			end
			DLE_ST_RMW_WR: begin
				m_hwdata_o = st_r.mod;
			end
			default: begin
				m_hwdata_o = s_hwdata_i;
			end
		endcase
	end

	// ========================================================================
	// sequencer
	logic accept_next;

	always_comb begin
		st_nxt = st_r;
		accept_next = 1'b0;
		case (st_r.state)
			DLE_ST_PASS, DLE_ST_RMW_WR, DLE_ST_EXT_RET: begin
				accept_next = accept;
				if (s_hready_o) begin
					st_nxt.state = DLE_ST_PASS;
				end
			end
			DLE_ST_RMW_RD: begin
				if (m_hready_i) begin
					st_nxt.data = {31'h0000_0000, fu_bit};
					st_nxt.mod = fu_mod;
					st_nxt.state = DLE_ST_RMW_WR;
				end
			end
			DLE_ST_EXT_RD: begin
				if (m_hready_i) begin
					st_nxt.data = fu_field;
					st_nxt.state = DLE_ST_EXT_RET;
				end
			end
			default: begin
				st_nxt.state = DLE_ST_PASS;
			end
		endcase
		if (accept_next && dec_load) begin
			// capture of the stripped address and attributes in cycle x
			st_nxt.addr = dec_addr;
			st_nxt.size = s_hsize_i;
			st_nxt.prot = s_hprot_i;
			st_nxt.lane = dec_lane;
			if (dec_ext) begin
				st_nxt.state = DLE_ST_EXT_RD;
				st_nxt.bpos = s_haddr_i[DLE_EXT_B_HI:DLE_EXT_B_LO];
				st_nxt.fw = s_haddr_i[DLE_EXT_W_HI:DLE_EXT_W_LO];
				st_nxt.set = 1'b0;
			end else begin
				st_nxt.state = DLE_ST_RMW_RD;
				st_nxt.bpos = s_haddr_i[DLE_BIT_HI:DLE_BIT_LO];
				st_nxt.fw = 4'h0;
				st_nxt.set = (dec_op == DLE_OP_SET);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '{state: DLE_ST_PASS, addr: 32'h0000_0000, size: 3'h0, prot: 4'h0,
				lane: 2'h0, set: 1'b0, bpos: 5'h00, fw: 4'h0,
				data: 32'h0000_0000, mod: 32'h0000_0000};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ========================================================================
	// control and status registers
	logic done;
	logic [1:0] kind;

	always_comb begin
		done = (st_r.state == DLE_ST_RMW_WR || st_r.state == DLE_ST_EXT_RET) && s_hready_o;
		if (st_r.state == DLE_ST_EXT_RET) begin
			kind = DLE_KIND_EXT;
		end else if (st_r.set) begin
			kind = DLE_KIND_SET;
		end else begin
			kind = DLE_KIND_CLEAR;
		end
	end

	dle_wb_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.done_i(done),
		.kind_i(kind),
		.busy_i(st_r.state != DLE_ST_PASS),
		.enable_o(enable)
	);

	// ========================================================================
	// checks
	default clocking dle_cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic rd_phase;
	assign rd_phase = (st_r.state == DLE_ST_RMW_RD) || (st_r.state == DLE_ST_EXT_RD);

	first_dp_stall_a: assert property (rd_phase |-> !s_hready_o)
		else $error("core not stalled in first data phase");
	fwd_strip_a: assert property (accept && dec_load |-> !m_hwrite_o
		&& m_haddr_o[31:20] == (dec_space == DLE_SPACE_SRAM ? 12'h200 : 12'h400))
		else $error("decorated read not forwarded stripped");
	capture_attr_a: assert property (accept && dec_load |=> rd_phase
		&& st_r.addr == $past(m_haddr_o) && st_r.size == $past(s_hsize_i))
		else $error("address or attributes not captured");
	rmw_write_a: assert property (st_r.state == DLE_ST_RMW_RD |-> m_hwrite_o
		&& m_htrans_o == DLE_HTRANS_NONSEQ && m_haddr_o == st_r.addr)
		else $error("write not reissued to captured address");
	ext_idle_a: assert property (st_r.state == DLE_ST_EXT_RD |-> m_htrans_o == DLE_HTRANS_IDLE
		&& !m_hwrite_o)
		else $error("extract issued a transfer in x+1");
	rmw_hold_a: assert property (st_r.state == DLE_ST_RMW_RD && !m_hready_i
		|=> st_r.state == DLE_ST_RMW_RD && m_haddr_o == $past(m_haddr_o))
		else $error("read-modify-write address phase disturbed");
	mod_bit_a: assert property (st_r.state == DLE_ST_RMW_RD && m_hready_i
		|=> ((st_r.mod >> {st_r.lane, 3'b000}) >> (st_r.size == DLE_SIZE_BYTE ?
		{2'b00, st_r.bpos[2:0]} : st_r.size == DLE_SIZE_HALF ? {1'b0, st_r.bpos[3:0]}
		: st_r.bpos)) % 32'h2 == {31'h0, st_r.set})
		else $error("selected bit not modified as decoded");
	bit_return_a: assert property (st_r.state == DLE_ST_RMW_WR |-> s_hrdata_o[31:1] == 31'h0
		&& s_hready_o == m_hready_i && m_hwdata_o == st_r.mod)
		else $error("bit return or write data wrong");
	ext_width_a: assert property (st_r.state == DLE_ST_EXT_RD && m_hready_i
		|=> s_hready_o && (s_hrdata_o >> ({1'b0, st_r.fw} + 5'h01)) == 32'h0)
		else $error("extract result wider than field");
	wait_pass_a: assert property (st_r.state == DLE_ST_PASS |-> s_hready_o == m_hready_i)
		else $error("wait state not passed to core");

	clear_seen_c: cover property (st_r.state == DLE_ST_RMW_WR && !st_r.set && s_hready_o);
	set_seen_c: cover property (st_r.state == DLE_ST_RMW_WR && st_r.set && s_hready_o);
	ext_seen_c: cover property (st_r.state == DLE_ST_EXT_RET);
	waited_rmw_c: cover property (st_r.state == DLE_ST_RMW_RD && !m_hready_i [*2]);
endmodule

// >>> bench/dle_mem_model.sv
// Purpose: behavioural memory slave on the far side of the engine
// Assumes: AHB single transfers, 256 words, wait states set by the bench
// Notes: read data shows a moving pattern outside valid data phases
`timescale 1ns/1ns
module dle_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic [3:0] waits_i,
	output logic [31:0] hrdata_o,
	output logic hready_o,
	output logic hresp_o
);
	logic [31:0] mem [0:255];
	logic [31:0] noise_r = 32'h0;
	logic [31:0] ph_a;
	logic [2:0] ph_s;
	logic [3:0] cnt_r;
	logic ph_v;
	logic ph_w;
	// ========================================================================
	// data phase
	assign hready_o = !ph_v || cnt_r == 4'h0;
	assign hresp_o = 1'b0;
	assign hrdata_o = (ph_v && !ph_w && hready_o) ? mem[ph_a[9:2]] : noise_r;
	always @(posedge clk_i) begin
		noise_r <= {noise_r[30:0], ~noise_r[31]};
		if (rst_i) begin
			ph_v <= 1'b0;
			cnt_r <= 4'h0;
		end else if (hready_o) begin
			if (ph_v && ph_w) begin
				for (int i = 0; i < 4; i++) begin
					if (ph_s > 3'h1 || (ph_s == 3'h1 && i[1] == ph_a[1]) || i[1:0] == ph_a[1:0]) begin
						mem[ph_a[9:2]][i * 8 +: 8] <= hwdata_i[i * 8 +: 8];
					end
				end
			end
			ph_v <= htrans_i[1];
			ph_a <= haddr_i;
			ph_w <= hwrite_i;
			ph_s <= hsize_i;
			cnt_r <= waits_i;
		end else begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule

// >>> bench/tb_decorated_load_engine.sv
// Purpose: self-checking bench of the decorated load engine
// Assumes: memory model on the far side, core and register bus driven by tasks
// Notes: reset held three cycles, every wait bounded
`timescale 1ns/1ns
module tb_decorated_load_engine import dle_pkg::*;;
	localparam logic [31:0] W0 = 32'h5AC3_3CA5;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] s_haddr = 32'h0;
	logic [1:0] s_htrans = 2'h0;
	logic [2:0] s_hsize = 3'h0;
	logic [3:0] waits = 4'h0;
	logic [3:0] s_hprot = 4'h3;
	logic s_hwrite = 1'b0;
	logic [31:0] s_hwdata = 32'h0;
	logic [3:0] wb_sel = 4'h0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] s_hrdata_o, m_haddr_o, m_hwdata_o, m_hrdata_i, wb_dat_o;
	logic [1:0] m_htrans_o;
	logic [2:0] m_hsize_o;
	logic [3:0] m_hprot_o;
	logic s_hready_o, s_hresp_o, m_hwrite_o, m_hready_i, m_hresp_i, wb_ack_o;
	logic [32:0] mlog[$];
	logic [6:0] alog[$];
	int n_mismatch = 0;
	int cmp_count = 0;
	always #20 clk_i = ~clk_i;
	dle_engine dut (.clk_i(clk_i), .rst_i(rst_i), .s_haddr_i(s_haddr), .s_htrans_i(s_htrans),
		.s_hwrite_i(s_hwrite), .s_hsize_i(s_hsize), .s_hprot_i(s_hprot),
		.s_hwdata_i(s_hwdata),
		.s_hrdata_o(s_hrdata_o), .s_hready_o(s_hready_o), .s_hresp_o(s_hresp_o),
		.m_haddr_o(m_haddr_o), .m_htrans_o(m_htrans_o), .m_hwrite_o(m_hwrite_o),
		.m_hsize_o(m_hsize_o), .m_hprot_o(m_hprot_o), .m_hwdata_o(m_hwdata_o),
		.m_hrdata_i(m_hrdata_i), .m_hready_i(m_hready_i), .m_hresp_i(m_hresp_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	dle_mem_model mem_m (.clk_i(clk_i), .rst_i(rst_i), .haddr_i(m_haddr_o),
		.htrans_i(m_htrans_o), .hwrite_i(m_hwrite_o), .hsize_i(m_hsize_o),
		.hwdata_i(m_hwdata_o), .waits_i(waits), .hrdata_o(m_hrdata_i),
		.hready_o(m_hready_i), .hresp_o(m_hresp_i));
	// ========================================================================
	// memory side transfer log
	always @(posedge clk_i) begin
		if (!rst_i && m_htrans_o[1] && m_hready_i) begin
			mlog.push_back({m_hwrite_o, m_haddr_o});
			alog.push_back({m_hprot_o, m_hsize_o});
		end
	end
	// ========================================================================
	// common tasks
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang();
		n_mismatch++;
		$display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		stop_test();
	endtask
	function automatic logic [31:0] cont(input logic [31:0] wd, input logic [2:0] sz,
		input logic [1:0] ln);
		if (sz == DLE_SIZE_BYTE) return {24'h0, wd[ln * 8 +: 8]};
		if (sz == DLE_SIZE_HALF) return {16'h0, wd[ln[1] * 16 +: 16]};
		return wd;
	endfunction
	task automatic wb_rw(input logic we, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= 4'hF;
		wb_adr <= ad;
		wb_dat <= d;
		@(negedge clk_i);
		for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 20) hang();
		// read data is held across the ack edge, so it is taken right at that edge
		@(posedge clk_i);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		wb_sel <= 4'h0;
		@(negedge clk_i);
	endtask
	task automatic dec_load(input logic [31:0] a, input logic [2:0] sz,
		output logic [31:0] rd, output int lo);
		int k;
		@(posedge clk_i);
		s_haddr <= a;
		s_htrans <= DLE_HTRANS_NONSEQ;
		s_hsize <= sz;
		s_hprot <= 4'h3;
		@(negedge clk_i);
		for (k = 0; k < 40 && s_hready_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 40) hang();
		@(posedge clk_i);
		// core side moves on at once, so only captured attributes may reach memory
		s_haddr <= 32'h0000_0000;
		s_htrans <= DLE_HTRANS_IDLE;
		s_hsize <= sz ^ 3'h1;
		s_hprot <= 4'hC;
		@(negedge clk_i);
		for (k = 0; k < 40 && s_hready_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 40) hang();
		lo = k;
		rd = s_hrdata_o;
		chk(33'(s_hresp_o), 33'h0);
		@(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic t_store();
		int k;
		mlog.delete();
		@(posedge clk_i);
		s_haddr <= 32'h2808_0014;
		s_htrans <= DLE_HTRANS_NONSEQ;
		s_hsize <= 3'h2;
		s_hwrite <= 1'b1;
		@(negedge clk_i);
		for (k = 0; k < 40 && s_hready_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 40) hang();
		@(posedge clk_i);
		s_htrans <= DLE_HTRANS_IDLE;
		s_hwrite <= 1'b0;
		s_hwdata <= 32'h1234_5678;
		@(negedge clk_i);
		for (k = 0; k < 40 && s_hready_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 40) hang();
		@(posedge clk_i);
		@(negedge clk_i);
		chk(mlog[0], 33'h1_2808_0014);
		chk({1'b0, mem_m.mem[5]}, 33'h0_1234_5678);
		$display("test decorated store pass done");
	endtask
	// ========================================================================
	// scenarios
	task automatic t_bit(input logic set, input logic [1:0] sp, input logic [2:0] sz,
		input logic [1:0] ln, input logic [4:0] b, input logic [3:0] wt);
		logic [31:0] a, ea, rd, c, ew;
		int lo;
		int bm;
		a = {1'b0, sp, set ? DLE_OP_SET : DLE_OP_CLEAR, b, 1'b1, 12'h800, 6'h05, ln};
		ea = ((sp == DLE_SPACE_SRAM) ? DLE_BASE_SRAM : DLE_BASE_PERIPH) | {12'h0, a[19:0]};
		waits <= wt;
		mem_m.mem[5] = W0;
		mlog.delete();
		alog.delete();
		dec_load(a, sz, rd, lo);
		c = cont(W0, sz, ln);
		bm = int'(b) % (8 << sz);
		ew = W0;
		ew[ln * 8 + bm] = set;
		chk(33'(rd), 33'(c[bm]));
		chk({1'b0, mem_m.mem[5]}, {1'b0, ew});
		chk(33'(lo), 33'(1 + 2 * wt));
		chk(33'(mlog.size()), 33'h2);
		chk(mlog[0], {1'b0, ea});
		chk(mlog[1], {1'b1, ea});
		chk(33'(alog[1]), 33'({4'h3, sz}));
		$display("test bit op %0d size %0d done", set, sz);
	endtask
	task automatic t_ext(input logic [1:0] sp, input logic [2:0] sz, input logic [1:0] ln,
		input logic [4:0] b, input logic [3:0] w, input logic [3:0] wt);
		logic [31:0] a, ea, rd, f;
		int lo;
		a = {1'b0, sp, 1'b1, b, w, 11'h400, 6'h05, ln};
		ea = ((sp == DLE_SPACE_SRAM) ? DLE_BASE_SRAM : DLE_BASE_PERIPH) | {13'h0, a[18:0]};
		waits <= wt;
		mem_m.mem[5] = W0;
		mlog.delete();
		dec_load(a, sz, rd, lo);
		f = (cont(W0, sz, ln) >> b) & ((32'h1 << (w + 1)) - 32'h1);
		chk(33'(rd), 33'(f));
		chk({1'b0, mem_m.mem[5]}, {1'b0, W0});
		chk(33'(lo), 33'(1 + wt));
		chk(33'(mlog.size()), 33'h1);
		chk(mlog[0], {1'b0, ea});
		$display("test extract b %0d w %0d done", b, w);
	endtask
	task automatic t_regs();
		logic [31:0] q;
		int lo;
		wb_rw(1'b0, DLE_REG_CTRL, 32'h0, q);
		chk(33'(q), 33'h1);
		wb_rw(1'b0, DLE_REG_STAT, 32'h0, q);
		chk(33'(q), 33'h0);
		wb_rw(1'b0, 8'h08, 32'h0, q);
		chk(33'(q), 33'h0);
		wb_rw(1'b1, DLE_REG_CTRL, 32'h0, q);
		mem_m.mem[5] = W0;
		mlog.delete();
		dec_load(32'h2800_0014, 3'h2, q, lo);
		chk(33'(q), {1'b0, W0});
		chk(mlog[0], 33'h0_2800_0014);
		wb_rw(1'b1, DLE_REG_CTRL, 32'h1, q);
		wb_rw(1'b1, DLE_REG_STAT, 32'h0, q);
		t_ext(DLE_SPACE_SRAM, DLE_SIZE_BYTE, 2'h0, 5'd2, 4'd3, 4'h0);
		wb_rw(1'b0, DLE_REG_STAT, 32'h0, q);
		chk(33'(q), 33'h0_0003_0001);
		$display("test registers done");
	endtask
	// ========================================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		t_regs();
		t_store();
		for (int s = 0; s < 3; s++) begin
			t_bit(1'b0, DLE_SPACE_SRAM, 3'(s), 2'((s == 0) ? 3 : (s == 1) ? 2 : 0), 5'd13, 4'(s));
			t_bit(1'b1, DLE_SPACE_PERIPH, 3'(s), 2'((s == 0) ? 1 : 0), 5'd30, 4'(2 - s));
		end
		t_ext(DLE_SPACE_SRAM, DLE_SIZE_BYTE, 2'h1, 5'd6, 4'd2, 4'h0);
		t_ext(DLE_SPACE_PERIPH, DLE_SIZE_HALF, 2'h2, 5'd3, 4'd5, 4'h1);
		t_ext(DLE_SPACE_SRAM, 3'h2, 2'h0, 5'd8, 4'd15, 4'h2);
		t_ext(DLE_SPACE_PERIPH, 3'h2, 2'h0, 5'd31, 4'd0, 4'h0);
		t_ext(DLE_SPACE_SRAM, DLE_SIZE_BYTE, 2'h0, 5'd9, 4'd1, 4'h3);
		stop_test();
	end
endmodule
